// File: core/hims_host_if.v
// Summary of operation
// - queue enable high turns write queue on
// - queue used only in parallel mode
// - sample queue enable at reset and clear
// - parallel mode: pins are data bits 11-13
// - serial, select low: spi clock and data
// - serial, select high: i2c scl and sda
// - spi shifts in on falling clock edge
// - i2c works at 100 and 400 khz
// - sda only pulled low, never driven high
// - spi output launched on rising clock edge
`include "hims_defs.vh"
module hims_host_if #(
    parameter DATA_W     = `HIMS_DATA_W,
    parameter FIFO_DEPTH = `HIMS_FIFO_DEPTH,
    parameter FIFO_AW    = 3,
    parameter SPI_BITS   = `HIMS_SPI_BITS
) (
    // clock and reset
    input  wire              sys_clk,
    input  wire              arst_n,
    // mode straps
    input  wire              serial_parallel_select,
    input  wire              queue_enable,
    input  wire              clear_req,
    // parallel bus
    input  wire [10:0]       par_data_low,
    input  wire              data_bit_11_protocol_select,
    input  wire              data_bit_12_serial_clock,
    input  wire              data_bit_13_serial_data_in,
    output wire              data_bit_13_serial_data_out,
    output wire              data_bit_13_serial_data_oe_n,
    input  wire              par_write_n,
    output wire              par_ready,
    // spi readback
    input  wire              spi_sync_n,
    output reg               spi_sdo,
    // core side word stream
    output wire              word_valid,
    input  wire              word_ready,
    output wire [DATA_W-1:0] word_data,
    output reg  [SPI_BITS-1:0] serial_word,
    output reg               serial_word_valid,
    output wire [1:0]        mode,
    output wire              queue_active
);
    // every pin below comes from the host's clock domain, so none
    // of them may be read before two flops have settled it.
    // the straps, strobes and serial pins share one bundle so that
    // edges seen on them keep their relative order.
    // limitation: a pin edge is seen 2-3 sys_clk late, which is why
    // the serial clock half period must stay at 3 sys_clk or more.
    // pin synchronisers: all external levels pass two flops
    wire [17:0] pin_s;
    hims_sync #(.W(18)) u_sync (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .async_in ({serial_parallel_select, queue_enable, clear_req, par_write_n, spi_sync_n,
                    data_bit_13_serial_data_in, data_bit_12_serial_clock,
                    data_bit_11_protocol_select, par_data_low[10:1]}),
        .sync_out (pin_s)
    );
    wire       ser_s   = pin_s[17];
    wire       qen_s   = pin_s[16];
    wire       clr_s   = pin_s[15];
    wire       wrn_s   = pin_s[14];
    wire       csn_s   = pin_s[13];
    wire       d13_s   = pin_s[12];
    wire       d12_s   = pin_s[11];
    wire       d11_s   = pin_s[10];
    wire [9:0] dlow_s  = pin_s[9:0];
    wire       d0_s;

    // bit 0 sampled by its own pair so the bundle above stays aligned
    hims_sync #(.W(1)) u_sync0 (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .async_in (par_data_low[0]),
        .sync_out (d0_s)
    );

    // the select pin wins over the protocol pin: while it is low the
    // bit 11 pin is plain data and its level must not pick a protocol.
    // decode is combinational so a strap change is seen everywhere
    // in the same cycle; the straps are expected to stay put while
    // a transfer is under way.
    // mode decode from synchronised straps
    reg [1:0] mode_next;
    always @* begin
        if (!ser_s) begin
            mode_next = `HIMS_MODE_PAR;
        end else if (!d11_s) begin
            mode_next = `HIMS_MODE_SPI;
        end else begin
            mode_next = `HIMS_MODE_I2C;
        end
    end
    assign mode = mode_next;

    // one-cycle history of the synchronised pins gives the edges.
    // the synchronisers reset to zero, so pins that idle high show a
    // false rising edge just after reset; the boot walk below keeps
    // the parallel strobe closed until those edges have passed.
    // the serial paths need no gate: the spi select is high and the i2c engine idle then.
    // edge history of the serial pins and strobes
    reg clk_d_reg;   // previous sclk/scl level
    reg sda_d_reg;   // previous sda level
    reg wrn_d_reg;   // previous write strobe
    reg clr_d_reg;   // previous clear level
    reg [2:0] boot_reg;  // one-hot walk; bit 2 marks settled straps
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_d_reg <= 1'b0;
            sda_d_reg <= 1'b1;
            wrn_d_reg <= 1'b1;
            clr_d_reg <= 1'b1;
            boot_reg  <= 3'h1;
        end else begin
            clk_d_reg <= d12_s;
            sda_d_reg <= d13_s;
            wrn_d_reg <= wrn_s;
            clr_d_reg <= clr_s;
            boot_reg  <= {boot_reg[1:0], 1'b0};
        end
    end
    wire clk_fall = clk_d_reg && !d12_s;
    wire clk_rise = !clk_d_reg && d12_s;
    wire clr_fall = clr_d_reg && !clr_s;

    // the strap is caught once the synchroniser holds the real pin
    // level (third edge after release), and again on each clear.
    // sampling earlier would catch the synchroniser's reset zero.
    // between those moments the pin is ignored, so a host may move
    // it freely without disturbing a queue that is already running.
    // queue enable strap caught after reset and on each clear
    reg qen_reg;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            qen_reg <= 1'b0;
        end else if (boot_reg[2] || clr_fall) begin
            qen_reg <= qen_s;
        end
    end
    // host must tie strap low in serial modes; gate anyway
    assign queue_active = qen_reg && (mode_next == `HIMS_MODE_PAR);

    // the word is taken when the strobe rises, from the same
    // synchronised sample as the strobe edge, so the host must hold
    // the bus a few sys_clk past the strobe's rising edge.
    // with the queue on, the host may write until par_ready drops;
    // with it off, only one word is held and par_ready says so.
    // trade-off: the bypass costs a stall per word but no storage.
    // parallel word capture on write strobe rising edge
    wire [DATA_W-1:0] par_word = {d13_s, d12_s, d11_s, dlow_s, d0_s};
    wire par_strobe = (mode_next == `HIMS_MODE_PAR) && !wrn_d_reg && wrn_s && (boot_reg == 3'h0);
    reg  [DATA_W-1:0] hold_reg;   // bypass holding word when queue off
    reg               hold_v_reg;
    wire              fifo_in_ready;
    wire              fifo_out_valid;
    wire [DATA_W-1:0] fifo_out_data;
    hims_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .flush     (!queue_active),
        .in_valid  (par_strobe && queue_active),
        .in_ready  (fifo_in_ready),
        .in_data   (par_word),
        .out_valid (fifo_out_valid),
        .out_ready (word_ready),
        .out_data  (fifo_out_data)
    );
    // without the queue only one word may be outstanding; ready tells host
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_reg   <= {DATA_W{1'b0}};
            hold_v_reg <= 1'b0;
        end else if (par_strobe && !queue_active && !hold_v_reg) begin
            hold_reg   <= par_word;
            hold_v_reg <= 1'b1;
        end else if (hold_v_reg && word_ready) begin
            hold_v_reg <= 1'b0;
        end
    end
    assign word_valid = queue_active ? fifo_out_valid : hold_v_reg;
    assign word_data  = queue_active ? fifo_out_data : hold_reg;
    assign par_ready  = queue_active ? fifo_in_ready : !hold_v_reg;

    // frames are framed by the select pin; raising it early resets
    // the bit count so a cut frame leaves no half word behind.
    // the last word received is echoed on the output pin during the
    // next frame, which is what lets several parts share one chain.
    // limitation: the oversampled clock caps the link far below the
    // rate a pin-clocked shifter would reach.
    // the output changes on the rising edge so it is steady at fall.
    // spi shifter: in on falling, out on rising
    reg [SPI_BITS-1:0]        sh_reg;
    reg [`HIMS_SPI_CNT_W-1:0] bit_cnt_reg;
    reg [SPI_BITS-1:0]        tx_reg;   // readback/daisy shift-out
    wire spi_on = (mode_next == `HIMS_MODE_SPI) && !csn_s;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_reg            <= {SPI_BITS{1'b0}};
            bit_cnt_reg       <= {`HIMS_SPI_CNT_W{1'b0}};
            tx_reg            <= {SPI_BITS{1'b0}};
            spi_sdo           <= 1'b0;
            serial_word       <= {SPI_BITS{1'b0}};
            serial_word_valid <= 1'b0;
        end else begin
            serial_word_valid <= 1'b0;
            if (!spi_on) begin
                bit_cnt_reg <= {`HIMS_SPI_CNT_W{1'b0}};
            end else if (clk_fall) begin
                // sample assumes host held data stable at this edge
                sh_reg <= {sh_reg[SPI_BITS-2:0], d13_s};
                if (bit_cnt_reg == SPI_BITS - 1) begin
                    bit_cnt_reg       <= {`HIMS_SPI_CNT_W{1'b0}};
                    serial_word       <= {sh_reg[SPI_BITS-2:0], d13_s};
                    serial_word_valid <= 1'b1;
                    tx_reg            <= {sh_reg[SPI_BITS-2:0], d13_s};  // daisy chain
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                end
            end else if (clk_rise) begin
                spi_sdo <= tx_reg[SPI_BITS-1];
                tx_reg  <= {tx_reg[SPI_BITS-2:0], 1'b0};
            end
        end
    end

    // start and stop are told apart from data by the data line moving
    // while the clock is high; everything else samples on the rise.
    // the ack is pulled on the fall after the eighth bit and let go
    // on the fall after the ack slot, so the line is never changed
    // while the clock is high.
    // a foreign address parks the engine until the next start or stop, so
    // later bytes meant for another part are never acked.
    // bytes after the address are acked but not passed on.
    // i2c target: write-only byte receiver with acks
    // oversampling at 50 mhz covers 100 and 400 khz alike
    reg [2:0] i2c_st_reg;
    reg [7:0] i2c_sh_reg;
    reg [3:0] i2c_cnt_reg;   // bits taken since start or last ack
    reg       sda_low_reg;   // pull-down request
    wire i2c_on   = (mode_next == `HIMS_MODE_I2C);
    wire i2c_start = i2c_on && d12_s && sda_d_reg && !d13_s;
    wire i2c_stop  = i2c_on && d12_s && !sda_d_reg && d13_s;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            i2c_st_reg  <= `HIMS_I2C_IDLE;
            i2c_sh_reg  <= 8'h00;
            i2c_cnt_reg <= 4'h0;
            sda_low_reg <= 1'b0;
        end else if (!i2c_on || i2c_stop) begin
            i2c_st_reg  <= `HIMS_I2C_IDLE;
            sda_low_reg <= 1'b0;
        end else if (i2c_start) begin
            i2c_st_reg  <= `HIMS_I2C_ADDR_S;
            i2c_cnt_reg <= 4'h0;
            sda_low_reg <= 1'b0;
        end else begin
            case (i2c_st_reg)
                `HIMS_I2C_ADDR_S, `HIMS_I2C_DATA: begin
                    if (clk_rise) begin
                        i2c_sh_reg  <= {i2c_sh_reg[6:0], d13_s};
                        i2c_cnt_reg <= i2c_cnt_reg + 4'h1;
                    end else if (clk_fall && i2c_cnt_reg == 4'h8) begin
                        // count of eight keeps the fall right after start out
                        // eight bits in: ack own address on write, data always
                        if (i2c_st_reg == `HIMS_I2C_DATA ||
                            i2c_sh_reg == {`HIMS_I2C_ADDR, 1'b0}) begin
                            sda_low_reg <= 1'b1;
                            i2c_st_reg  <= (i2c_st_reg == `HIMS_I2C_DATA) ? `HIMS_I2C_DACK : `HIMS_I2C_AACK;
                        end else begin
                            i2c_st_reg <= `HIMS_I2C_SKIP;
                        end
                    end
                end
                `HIMS_I2C_AACK, `HIMS_I2C_DACK: begin
                    if (clk_fall) begin
                        sda_low_reg <= 1'b0;
                        i2c_cnt_reg <= 4'h0;
                        i2c_st_reg  <= `HIMS_I2C_DATA;
                    end
                end
                `HIMS_I2C_SKIP: begin
                    sda_low_reg <= 1'b0;
                end
                default: begin
                    i2c_st_reg <= `HIMS_I2C_IDLE;
                end
            endcase
        end
    end

    // the pad only ever pulls low; the high level comes from the
    // board's pull-up, so two parts on one bus can never fight.
    // the enable is gated by the mode so a strap change mid-ack
    // releases the line at once.
    // sda open drain: data always low, enable active low when pulling
    assign data_bit_13_serial_data_out  = 1'b0;
    assign data_bit_13_serial_data_oe_n = !(i2c_on && sda_low_reg);
endmodule

// File: core/hims_defs.vh
`ifndef HIMS_DEFS_VH
`define HIMS_DEFS_VH
// interface modes
`define HIMS_MODE_PAR   2'h0
`define HIMS_MODE_SPI   2'h1
`define HIMS_MODE_I2C   2'h2
// parallel data word layout
`define HIMS_DATA_W     14
`define HIMS_MUX_LSB    11
`define HIMS_MUX_MSB    13
// serial word length for spi (24-bit frames)
`define HIMS_SPI_BITS   24
`define HIMS_SPI_CNT_W  5
// i2c target address (7 bits), arbitrary default
`define HIMS_I2C_ADDR   7'h2a
// fifo depth
`define HIMS_FIFO_DEPTH 8
// i2c engine states
`define HIMS_I2C_IDLE   3'h0
`define HIMS_I2C_ADDR_S 3'h1
`define HIMS_I2C_AACK   3'h2
`define HIMS_I2C_DATA   3'h3
`define HIMS_I2C_DACK   3'h4
`define HIMS_I2C_SKIP   3'h5
`endif

// File: core/hims_sync.v
// two-flop synchroniser for a bundle of pin levels
module hims_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         sys_clk,
    input  wire         arst_n,
    // async levels in, synchronised levels out
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_reg;  // first stage, read only by second stage
    reg [W-1:0] sync_reg;  // second stage

    // plain shift of two stages
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// File: core/hims_fifo.v
// small flip-flop fifo with valid/ready on both sides
module hims_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             arst_n,
    // synchronous flush
    input  wire             flush,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];  // storage in flops
    reg [AW-1:0]    wr_ptr_reg;           // write index
    reg [AW-1:0]    rd_ptr_reg;           // read index
    reg [AW:0]      count_reg;            // fill level

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    // full/empty straight from the count
    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rd_ptr_reg];

    // storage write, no reset needed on data
    always @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and count; wrap assumes power-of-two depth
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// File: tb/hims_host_if_monitor.sv
`include "hims_defs.vh"
module hims_host_if_monitor (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       arst_n,
    // host pins
    input wire logic       serial_parallel_select,
    input wire logic       data_bit_11_protocol_select,
    input wire logic       data_bit_12_serial_clock,
    input wire logic       par_write_n,
    input wire logic       data_bit_13_serial_data_out,
    input wire logic       data_bit_13_serial_data_oe_n,
    // core side
    input wire logic       word_valid,
    input wire logic       serial_word_valid,
    input wire logic [1:0] mode,
    input wire logic       queue_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       wr_d_reg;    // strobe one cycle ago
    logic       sck_d_reg;   // serial clock one cycle ago
    logic [3:0] wr_age_reg;  // cycles since strobe rose
    logic [3:0] sck_age_reg; // cycles since clock fell
    // ages saturate so a stale edge never looks recent
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_d_reg    <= 1'b1;
            sck_d_reg   <= 1'b1;
            wr_age_reg  <= 4'hf;
            sck_age_reg <= 4'hf;
        end else begin
            wr_d_reg    <= par_write_n;
            sck_d_reg   <= data_bit_12_serial_clock;
            wr_age_reg  <= (par_write_n && !wr_d_reg) ? 4'h0 : wr_age_reg + {3'h0, wr_age_reg != 4'hf};
            sck_age_reg <= (!data_bit_12_serial_clock && sck_d_reg) ? 4'h0 : sck_age_reg + {3'h0, sck_age_reg != 4'hf};
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    property p_queue_par; queue_active |-> mode == `HIMS_MODE_PAR; endproperty
    a_queue_par: assert property (p_queue_par) else $error("queue active outside parallel mode");
    property p_par_mode; !serial_parallel_select [*6] |-> mode == `HIMS_MODE_PAR; endproperty
    a_par_mode: assert property (p_par_mode) else $error("parallel mode not selected");
    property p_spi_mode; (serial_parallel_select && !data_bit_11_protocol_select) [*6] |-> mode == `HIMS_MODE_SPI;
    endproperty
    a_spi_mode: assert property (p_spi_mode) else $error("spi mode not selected");
    property p_i2c_mode; (serial_parallel_select && data_bit_11_protocol_select) [*6] |-> mode == `HIMS_MODE_I2C;
    endproperty
    a_i2c_mode: assert property (p_i2c_mode) else $error("i2c mode not selected");
    property p_sda_low; !data_bit_13_serial_data_oe_n |-> !data_bit_13_serial_data_out; endproperty
    a_sda_low: assert property (p_sda_low) else $error("data line driven high");
    property p_oe_mode; !data_bit_13_serial_data_oe_n |-> mode == `HIMS_MODE_I2C; endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("data line driven outside i2c");
    property p_word_lat; $rose(word_valid) |-> wr_age_reg <= 4'h6; endproperty
    a_word_lat: assert property (p_word_lat) else $error("word appeared without a write strobe");
    property p_spi_fall; serial_word_valid |-> sck_age_reg <= 4'h6 && mode == `HIMS_MODE_SPI; endproperty
    a_spi_fall: assert property (p_spi_fall) else $error("serial word not tied to falling clock");
endmodule

// File: tb/hims_host_model.sv
module hims_host_model (
    // clock
    input wire logic         sys_clk,
    // pins towards the device
    output logic [10:0]      par_data_low,
    output logic             b11,
    output logic             b12,
    output logic             b13,
    output logic             par_write_n,
    output logic             spi_sync_n,
    // pins from the device
    input wire logic         par_ready,
    input wire logic         sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle: strobes off, serial clock parked high
    initial begin
        par_data_low = 11'h7ff;
        b11 = 1'b0;
        b12 = 1'b1;
        b13 = 1'b1;
        par_write_n = 1'b1;
        spi_sync_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // word taken on strobe rise; bus inverted after so stale data never matches
    task automatic par_write(input logic [13:0] d);
        {b13, b12, b11, par_data_low} = d;
        par_write_n = 1'b0;
        tick(4);
        par_write_n = 1'b1;
        tick(4);
        {b13, b12, b11, par_data_low} = ~d;
    endtask
    // msb first, data set while clock high so it is steady at the fall
    task automatic spi_frame(input logic [23:0] w);
        b12 = 1'b1;
        tick(4);
        spi_sync_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            b13 = w[i];
            tick(4);
            b12 = 1'b0;
            tick(4);
            b12 = 1'b1;
        end
        spi_sync_n = 1'b1;
        b13 = ~w[0];
    endtask
    // start, one address byte, ack slot, stop; h is half the scl period
    task automatic i2c_addr(input logic [7:0] a, input int h, output logic ack);
        b12 = 1'b1;
        b13 = 1'b1;
        tick(h);
        b13 = 1'b0;
        tick(h);
        for (int i = 7; i >= -1; i--) begin
            b12 = 1'b0;
            tick(h / 2);
            b13 = (i < 0) ? 1'b1 : a[i];
            tick(h / 2);
            b12 = 1'b1;
            tick(h / 2);
            ack = !sda;
            tick(h / 2);
        end
        b12 = 1'b0;
        b13 = 1'b0;
        tick(h);
        b12 = 1'b1;
        tick(h);
        b13 = 1'b1;
        tick(h);
    endtask
endmodule

// File: tb/tb.sv
`include "hims_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, arst_n, sps, qen, clr, word_ready, b11, b12, b13, wr_n, sync_n, ack;
    logic [10:0] pdl;
    wire         sdo_out, oe_n, par_ready, spi_sdo, word_valid, swv, qact;
    wire  [13:0] word_data;
    wire  [23:0] serial_word;
    wire  [1:0]  mode;
    wire         sda = b13 & oe_n; // open-drain wired and
    int          n_mismatch = 0;
    int          checks_done = 0;
    hims_host_if dut (.sys_clk(sys_clk), .arst_n(arst_n), .serial_parallel_select(sps), .queue_enable(qen),
        .clear_req(clr), .par_data_low(pdl), .data_bit_11_protocol_select(b11), .data_bit_12_serial_clock(b12),
        .data_bit_13_serial_data_in(sda), .data_bit_13_serial_data_out(sdo_out),
        .data_bit_13_serial_data_oe_n(oe_n), .par_write_n(wr_n), .par_ready(par_ready), .spi_sync_n(sync_n),
        .spi_sdo(spi_sdo), .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
        .serial_word(serial_word), .serial_word_valid(swv), .mode(mode), .queue_active(qact));
    hims_host_model host (.sys_clk(sys_clk), .par_data_low(pdl), .b11(b11), .b12(b12), .b13(b13),
        .par_write_n(wr_n), .spi_sync_n(sync_n), .par_ready(par_ready), .sda(sda));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // straps are set first, then a 2 cycle reset
    task automatic do_reset(input logic s, input logic q);
        sps = s;
        qen = q;
        arst_n = 1'b0;
        host.tick(2);
        arst_n = 1'b1;
        host.tick(8);
    endtask
    // fill the queue with the far side stalled, then drain in order
    task automatic t_queue;
        host.b11 = 1'b1;
        do_reset(1'b0, 1'b1);
        chk("queue_active", qact, 1'b1);
        chk("mode", mode, `HIMS_MODE_PAR);
        for (int i = 0; i < 8; i++) host.par_write({i[2:0], 11'h5a5 ^ i[10:0]});
        host.tick(4);
        chk("par_ready full", par_ready, 1'b0);
        for (int i = 0; i < 8; i++) begin
            for (int n = 0; n < 20 && word_valid !== 1'b1; n++) host.tick(1);
            chk("word_data", word_data, {i[2:0], 11'h5a5 ^ i[10:0]});
            word_ready = 1'b1;
            host.tick(1);
            word_ready = 1'b0;
        end
        host.tick(4);
        chk("word_valid empty", word_valid, 1'b0);
        $display("test queue done");
    endtask
    // strap read at reset, ignored after, read again on clear
    task automatic t_strap;
        do_reset(1'b0, 1'b0);
        chk("queue_active off", qact, 1'b0);
        qen = 1'b1;
        host.tick(8);
        chk("queue_active held", qact, 1'b0);
        clr = 1'b0;
        host.tick(8);
        clr = 1'b1;
        host.tick(8);
        chk("queue_active clear", qact, 1'b1);
        $display("test strap done");
    endtask
    task automatic t_spi;
        host.b11 = 1'b0;
        do_reset(1'b1, 1'b0);
        chk("mode", mode, `HIMS_MODE_SPI);
        chk("queue_active", qact, 1'b0);
        host.spi_frame(24'h9c35a1);
        for (int n = 0; n < 20 && swv !== 1'b1; n++) host.tick(1);
        chk("serial_word", serial_word, 24'h9c35a1);
        chk("word_valid", word_valid, 1'b0);
        $display("test spi done");
    endtask
    // both bus rates, then a foreign address that must not be acked
    task automatic t_i2c;
        host.b11 = 1'b1;
        do_reset(1'b1, 1'b0);
        chk("mode", mode, `HIMS_MODE_I2C);
        host.i2c_addr({`HIMS_I2C_ADDR, 1'b0}, 250, ack);
        chk("ack 100k", ack, 1'b1);
        host.i2c_addr({`HIMS_I2C_ADDR, 1'b0}, 63, ack);
        chk("ack 400k", ack, 1'b1);
        host.i2c_addr({`HIMS_I2C_ADDR ^ 7'h01, 1'b0}, 63, ack);
        chk("ack foreign", ack, 1'b0);
        chk("sda released", sda, 1'b1);
        $display("test i2c done");
    endtask
    initial begin
        arst_n = 1'b0;
        sps = 1'b0;
        qen = 1'b0;
        clr = 1'b1;
        word_ready = 1'b0;
        t_queue();
        t_strap();
        t_spi();
        t_i2c();
        finish_test();
    end
    // watchdog well past the longest expected run
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        finish_test();
    end
endmodule
bind hims_host_if hims_host_if_monitor mon (.sys_clk(sys_clk), .arst_n(arst_n),
    .serial_parallel_select(serial_parallel_select), .data_bit_11_protocol_select(data_bit_11_protocol_select),
    .data_bit_12_serial_clock(data_bit_12_serial_clock), .par_write_n(par_write_n),
    .data_bit_13_serial_data_out(data_bit_13_serial_data_out),
    .data_bit_13_serial_data_oe_n(data_bit_13_serial_data_oe_n), .word_valid(word_valid),
    .serial_word_valid(serial_word_valid), .mode(mode), .queue_active(queue_active));
